// File: rtl/adcp_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Start-strobe fall samples, rise starts conversion
// - Start strobe works without chip select
// - Select fall resets counters, enables bus
// - Select rise disables bus and write
// - Select gates output in start-strobe modes
// - Bus driven only while selected and strobed
// - End of conversion in interrupt modes: interrupt falls
// - Interrupt low on fifth system clock fall
// - Interrupt held until select or read rises
// - Read fall starts conversion if selected
// - Continuous: read fall converts, releases old result
// - Read rise is read strobe, bus released
// - Trigger source chosen by configuration
// - System clock from oscillator or external input
// - Two result bits per system clock
// - Conversion takes five system clocks
// - Serial bits assembled into parallel word
// - Bus bit zero carries the LSB
// - Four modes: interrupt/continuous, mono/dual
// - Dual mode samples both channels together
// - Inputs single-ended or differential pairs
// - Two's complement and resolution programmable
// - Index bits pick register, eight bits stored
// - Power-down: reads return both configs, no conversions
// - Bit four selects input type
module adcp_ctrl
    import adcp_pkg::*;
#(
    parameter int unsigned OSC_DIV_P = OSC_DIV,
    parameter int unsigned DEPTH_P   = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Host strobes
    input  wire logic        cs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        conversion_start_n,
    // Data bus pins
    input  wire logic [9:0]  data_in,
    output logic      [9:0]  data_out,
    output logic             data_oe_n,
    // Open-drain interrupt pin
    output logic             int_out,
    output logic             int_oe_n,
    // External clock pin
    input  wire logic        external_clock_in,
    // Conversion core
    input  wire logic [1:0]  core_bits_a,
    input  wire logic [1:0]  core_bits_b,
    output logic             sample_hold,
    output logic             core_step,
    // Configuration seen by the analog side
    output logic [1:0]       chan_sel,
    output logic             input_type_select,
    output logic             dual_mode,
    output logic             power_down
);
    localparam int unsigned DW = $clog2(OSC_DIV_P + 1);

    // Strobe history for edge detection
    logic cs_n_q;
    logic rd_n_q;
    logic wr_n_q;
    logic cst_n_q;
    logic ext_q;
    logic cs_fall;
    logic cs_rise;
    logic rd_fall;
    logic rd_rise;
    logic wr_rise;
    logic cst_fall;
    logic cst_rise;

    assign cs_fall  = cs_n_q && !cs_n;
    assign cs_rise  = !cs_n_q && cs_n;
    assign rd_fall  = rd_n_q && !rd_n;
    assign rd_rise  = !rd_n_q && rd_n;
    assign wr_rise  = !wr_n_q && wr_n;
    assign cst_fall = cst_n_q && !conversion_start_n;
    assign cst_rise = !cst_n_q && conversion_start_n;

    // Configuration registers
    logic [7:0] cfg_zero_q;        // config_reg_zero
    logic [7:0] cfg_one_q;         // config_reg_one
    logic [9:0] wr_data_q;         // Bus value held while write is low
    logic       mode_cont;
    logic       mode_dual;
    logic       use_conversion_start_n;
    logic       pwrdn;

    assign mode_cont  = cfg_zero_q[CR0_CONT_BIT];
    assign mode_dual  = cfg_zero_q[CR0_DUAL_BIT];
    assign use_conversion_start_n = cfg_one_q[CR1_CONVERSION_START_N_BIT] && !mode_cont;
    assign pwrdn      = cfg_one_q[CR1_PWRDN_BIT];

    // Sequencer and engine state
    adcp_state_e state_q;
    logic [STEP_W-1:0] step_q;     // Completed system clock steps
    logic [9:0] shift_a_q;         // Channel A serial result
    logic [9:0] shift_b_q;         // Channel B serial result
    logic       push_chan_q;       // Which channel is being pushed
    logic       dual_run_q;        // Dual mode latched at start
    logic [DW-1:0] div_q;          // Internal oscillator divider
    logic       sys_fall;          // System clock falling edge enable
    logic       start_req;         // Conversion start event
    logic       samp_req;          // Sampling start event

    // Result FIFO links
    adcp_word_s fifo_in;
    adcp_word_s fifo_out;
    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic       fifo_pop;

    // Readback and bus state
    logic       rb_idx_q;          // Power-down readback pointer
    logic       from_fifo_q;       // Bus word came from the FIFO
    logic       int_low_q;         // Interrupt pin pulled low

    // Edge history, sampled each cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            cs_n_q  <= 1'b1;
            rd_n_q  <= 1'b1;
            wr_n_q  <= 1'b1;
            cst_n_q <= 1'b1;
            ext_q   <= 1'b0;
        end else begin
            cs_n_q  <= cs_n;
            rd_n_q  <= rd_n;
            wr_n_q  <= wr_n;
            cst_n_q <= conversion_start_n;
            ext_q   <= external_clock_in;
        end
    end

    // Internal oscillator divider, restarted by select fall
    always_ff @(posedge clk) begin
        if (rst || cs_fall) begin
            div_q <= '0;
        end else if (div_q == DW'(OSC_DIV_P - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DW'(1);
        end
    end

    // System clock falling edge from the chosen source
    always_comb begin
        if (cfg_one_q[CR1_EXTCLK_BIT]) begin
            sys_fall = ext_q && !external_clock_in;
        end else begin
            sys_fall = (div_q == DW'(OSC_DIV_P - 1));
        end
    end

    // Trigger decode per mode
    always_comb begin
        samp_req  = 1'b0;
        start_req = 1'b0;
        if (!pwrdn) begin
            if (use_conversion_start_n) begin
                samp_req  = cst_fall;
                start_req = cst_rise;
            end else begin
                start_req = rd_fall && !cs_n;
            end
        end
    end

    // Write capture into the indexed register
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_data_q  <= '0;
            cfg_zero_q <= CR0_RESET;
            cfg_one_q  <= CR1_RESET;
        end else begin
            // Hold bus value while the write strobe is low
            if (!wr_n && !cs_n) begin
                wr_data_q <= data_in;
            end
            // Store on write rise, only while selected
            if (wr_rise && !cs_n) begin
                case (wr_data_q[IDX_HI:IDX_LO])
                    IDX_CFG_ZERO: cfg_zero_q <= wr_data_q[CFG_W-1:0];
                    IDX_CFG_ONE:  cfg_one_q  <= wr_data_q[CFG_W-1:0];
                    default:      ;
                endcase
            end
        end
    end

    // Conversion sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            step_q      <= '0;
            push_chan_q <= 1'b0;
            dual_run_q  <= 1'b0;
        end else begin
            case (state_q)
                // Waiting for a trigger
                ST_IDLE: begin
                    push_chan_q <= 1'b0;
                    step_q      <= '0;
                    dual_run_q  <= mode_dual;
                    if (samp_req) begin
                        state_q <= ST_SAMPLE;
                    end else if (start_req) begin
                        state_q <= ST_CONV;
                    end
                end
                // Tracking inputs until the start edge
                ST_SAMPLE: begin
                    if (start_req) begin
                        state_q <= ST_CONV;
                    end
                end
                // Five system clock steps
                ST_CONV: begin
                    if (sys_fall) begin
                        step_q <= step_q + STEP_W'(1);
                        if (step_q == STEP_W'(CONV_STEPS - 1)) begin
                            state_q <= ST_PUSH;
                        end
                    end
                end
                // Hand words to the FIFO, stalled while full
                ST_PUSH: begin
                    if (fifo_in_ready) begin
                        if (dual_run_q && !push_chan_q) begin
                            push_chan_q <= 1'b1;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Two bits per step into both channel shifters
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_a_q <= '0;
            shift_b_q <= '0;
        end else if (state_q == ST_CONV && sys_fall) begin
            shift_a_q <= {shift_a_q[7:0], core_bits_a};
            shift_b_q <= {shift_b_q[7:0], core_bits_b};
        end
    end

    // Output word: resolution mask then code format
    always_comb begin
        fifo_in.chan = push_chan_q;
        fifo_in.data = push_chan_q ? shift_b_q : shift_a_q;
        case (cfg_one_q[CR1_RES_LO +: 2])
            RES_8:   fifo_in.data = fifo_in.data & MASK_8;
            RES_4:   fifo_in.data = fifo_in.data & MASK_4;
            default: fifo_in.data = fifo_in.data;
        endcase
        if (!cfg_one_q[CR1_BINARY_BIT]) begin
            fifo_in.data = fifo_in.data ^ SIGN_BIT;
        end
    end

    assign fifo_in_valid = (state_q == ST_PUSH);
    assign fifo_pop      = rd_rise && from_fifo_q && !cs_n_q;

    // Result buffer between engine and bus
    adcp_fifo #(
        .WIDTH ($bits(adcp_word_s)),
        .DEPTH (DEPTH_P)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out)
    );

    // Interrupt pin: pulled low at end of conversion in interrupt modes
    always_ff @(posedge clk) begin
        if (rst) begin
            int_low_q <= 1'b0;
        end else if (cs_rise || rd_rise) begin
            int_low_q <= 1'b0;
        end else if (state_q == ST_CONV && sys_fall && !mode_cont
                     && step_q == STEP_W'(CONV_STEPS - 1)) begin
            int_low_q <= 1'b1;
        end
    end

    // Power-down readback pointer
    always_ff @(posedge clk) begin
        if (rst || cs_fall || !pwrdn) begin
            rb_idx_q <= 1'b0;
        end else if (rd_rise && !cs_n_q) begin
            rb_idx_q <= !rb_idx_q;
        end
    end

    // Bus word latched on read fall
    always_ff @(posedge clk) begin
        if (rst) begin
            data_out    <= '0;
            from_fifo_q <= 1'b0;
        end else if (cs_fall) begin
            from_fifo_q <= 1'b0;
        end else if (rd_fall && !cs_n) begin
            if (pwrdn) begin
                data_out    <= rb_idx_q ? {IDX_CFG_ONE, cfg_one_q}
                                        : {IDX_CFG_ZERO, cfg_zero_q};
                from_fifo_q <= 1'b0;
            end else if (fifo_out_valid) begin
                data_out    <= fifo_out.data;
                from_fifo_q <= 1'b1;
            end else begin
                from_fifo_q <= 1'b0;
            end
        end else if (rd_rise) begin
            from_fifo_q <= 1'b0;
        end
    end

    // Bus drive: only while selected and reading
    always_ff @(posedge clk) begin
        if (rst) begin
            data_oe_n <= 1'b1;
        end else begin
            data_oe_n <= cs_n || rd_n;
        end
    end

    // Registered pin and core outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            int_out           <= 1'b0;
            int_oe_n          <= 1'b1;
            sample_hold       <= 1'b0;
            core_step         <= 1'b0;
            chan_sel          <= '0;
            input_type_select <= 1'b0;
            dual_mode         <= 1'b0;
            power_down        <= 1'b0;
        end else begin
            int_out           <= 1'b0;
            int_oe_n          <= !int_low_q;
            sample_hold       <= (state_q == ST_SAMPLE);
            core_step         <= (state_q == ST_CONV) && sys_fall;
            chan_sel          <= cfg_zero_q[CR0_CHAN_LO +: 2];
            input_type_select <= cfg_zero_q[CR0_INTYPE_BIT];
            dual_mode         <= mode_dual;
            power_down        <= pwrdn;
        end
    end

endmodule

// File: rtl/adcp_pkg.sv
package adcp_pkg;

    // Data bus and configuration widths
    localparam int unsigned DATA_W = 10;
    localparam int unsigned CFG_W  = 8;

    // Register index field on the top two bus bits
    localparam int unsigned IDX_HI = 9;
    localparam int unsigned IDX_LO = 8;
    localparam logic [1:0]  IDX_CFG_ZERO = 2'h0;
    localparam logic [1:0]  IDX_CFG_ONE  = 2'h1;

    // Configuration register zero fields
    localparam int unsigned CR0_CHAN_LO    = 0;
    localparam int unsigned CR0_CONT_BIT   = 3;
    localparam int unsigned CR0_DUAL_BIT   = 2;
    localparam int unsigned CR0_INTYPE_BIT = 4;

    // Configuration register one fields
    localparam int unsigned CR1_RES_LO     = 0;
    localparam int unsigned CR1_BINARY_BIT = 2;
    localparam int unsigned CR1_PWRDN_BIT  = 3;
    localparam int unsigned CR1_CONVERSION_START_N_BIT = 6;
    localparam int unsigned CR1_EXTCLK_BIT = 7;

    // Reset values of both configuration registers
    localparam logic [7:0] CR0_RESET = 8'h00;
    localparam logic [7:0] CR1_RESET = 8'h00;

    // Resolution codes
    localparam logic [1:0] RES_10 = 2'h0;
    localparam logic [1:0] RES_8  = 2'h1;
    localparam logic [1:0] RES_4  = 2'h2;

    // Result masks per resolution and sign flip for two's complement
    localparam logic [9:0] MASK_8   = 10'h3FC;
    localparam logic [9:0] MASK_4   = 10'h3C0;
    localparam logic [9:0] SIGN_BIT = 10'h200;

    // Conversion length in system clock steps, two bits per step
    localparam int unsigned CONV_STEPS = 5;
    localparam int unsigned STEP_W     = 3;

    // Internal oscillator period and clock period
    localparam int unsigned OSC_PERIOD_NS = 100;
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned OSC_DIV = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Result FIFO depth
    localparam int unsigned FIFO_DEPTH = 16;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV   = 2'b10,
        ST_PUSH   = 2'b11
    } adcp_state_e;

    // One result word with its channel tag
    typedef struct packed {
        logic       chan;
        logic [9:0] data;
    } adcp_word_s;

endpackage

// File: rtl/adcp_fifo.sv
`timescale 1ns/1ps
module adcp_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];   // Storage
    logic [AW-1:0]    wr_q;            // Write index
    logic [AW-1:0]    rd_q;            // Read index
    logic [AW:0]      cnt_q;           // Fill count
    logic             push;
    logic             pop;

    // Handshakes
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule

// File: bench/adcp_core_model.sv
`timescale 1ns/1ps
module adcp_core_model (
    // Clock
    input  wire logic       clk,
    // Sequencer outputs
    input  wire logic       sample_hold,
    input  wire logic       core_step,
    // Analog levels as bit pairs
    input  wire logic [1:0] level_a,
    input  wire logic [1:0] level_b,
    // Bits to the sequencer
    output logic      [1:0] core_bits_a,
    output logic      [1:0] core_bits_b
);
    // Cycles since the last step
    logic [3:0] quiet_q = 4'hF;

    // Quiet time after each step
    always_ff @(posedge clk) begin
        if (core_step) begin
            quiet_q <= 4'h0;
        end else if (quiet_q != 4'hF) begin
            quiet_q <= quiet_q + 4'h1;
        end
    end

    // Both channels held together, steady while converting
    always_ff @(posedge clk) begin
        if (sample_hold || quiet_q > 4'h8) begin
            core_bits_a <= level_a;
            core_bits_b <= level_b;
        end
    end
endmodule

// File: bench/adcp_ctrl_assertions.sv
`timescale 1ns/1ps
module adcp_ctrl_assertions
    import adcp_pkg::*;
#(
    parameter int unsigned OSC_DIV_P = OSC_DIV,
    parameter int unsigned DEPTH_P   = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Host side
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic [9:0] data_in,
    input wire logic       data_oe_n,
    input wire logic       int_oe_n,
    // Core and configuration
    input wire logic       core_step,
    input wire logic [1:0] chan_sel,
    input wire logic       input_type_select,
    input wire logic       dual_mode,
    input wire logic       power_down
);
    // Steps since release, release seen last edge
    logic [3:0] steps_q;
    logic       rel_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Count core steps, cleared on release
    always_ff @(posedge clk) begin
        if (rst || $rose(int_oe_n)) begin
            steps_q <= 4'h0;
        end else if (core_step && steps_q != 4'hF) begin
            steps_q <= steps_q + 4'h1;
        end
    end

    // Select or read rise
    always_ff @(posedge clk) begin
        rel_q <= !rst && ($rose(cs_n) || $rose(rd_n));
    end

    // Write cycles to each register
    sequence s_wr_zero;
        (!wr_n && !cs_n && data_in[9:8] == IDX_CFG_ZERO) ##1 (wr_n && !cs_n);
    endsequence
    sequence s_wr_one;
        (!wr_n && !cs_n && data_in[9:8] == IDX_CFG_ONE) ##1 (wr_n && !cs_n);
    endsequence

    property p_bus_on;
        !cs_n && !rd_n |=> !data_oe_n;
    endproperty
    a_bus_on: assert property (p_bus_on) else $error("bus idle on read");
    property p_bus_off;
        cs_n || rd_n |=> data_oe_n;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus driven");
    property p_int_hold;
        !int_oe_n && !$rose(cs_n) && !$rose(rd_n) && !rel_q |=> !int_oe_n;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("int lost");
    property p_int_release;
        !int_oe_n && ($rose(rd_n) || $rose(cs_n)) |-> ##[1:2] int_oe_n;
    endproperty
    a_int_release: assert property (p_int_release) else $error("int stuck");
    property p_int_steps;
        $fell(int_oe_n) |-> steps_q == 4'h5;
    endproperty
    a_int_steps: assert property (p_int_steps) else $error("int step count");
    property p_cfg0_wr;
        s_wr_zero |-> ##2 chan_sel == $past(data_in[1:0], 3)
            && dual_mode == $past(data_in[2], 3)
            && input_type_select == $past(data_in[4], 3);
    endproperty
    a_cfg0_wr: assert property (p_cfg0_wr) else $error("cfg zero");
    property p_cfg1_wr;
        s_wr_one |-> ##2 power_down == $past(data_in[3], 3);
    endproperty
    a_cfg1_wr: assert property (p_cfg1_wr) else $error("cfg one");
    property p_cfg_stable;
        $changed({chan_sel, dual_mode, input_type_select, power_down})
            |-> $past(wr_n, 2) && !$past(wr_n, 3) && !$past(cs_n, 2);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable) else $error("cfg moved");
    property p_pd_idle;
        power_down && int_oe_n |=> int_oe_n && !core_step;
    endproperty
    a_pd_idle: assert property (p_pd_idle) else $error("converts in pd");
endmodule

bind adcp_ctrl adcp_ctrl_assertions #(
    .OSC_DIV_P(OSC_DIV_P),
    .DEPTH_P  (DEPTH_P)
) i_chk (
    .clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .data_in(data_in), .data_oe_n(data_oe_n), .int_oe_n(int_oe_n),
    .core_step(core_step), .chan_sel(chan_sel), .input_type_select(input_type_select),
    .dual_mode(dual_mode), .power_down(power_down)
);

// File: bench/test_adcp_ctrl.sv
`timescale 1ns/1ps
module test_adcp_ctrl
    import adcp_pkg::*;
();
    // Clock, reset, strobes
    logic       clk, rst, cs_n, rd_n, wr_n, conversion_start_n, ext_clk;
    // Bus wire and design outputs
    logic [9:0] host_d, bus, data_out;
    logic       int_out, data_oe_n, int_oe_n, sample_hold, core_step;
    logic       input_type_select, dual_mode, power_down;
    logic [1:0] chan_sel, bits_a, bits_b, la, lb;
    // Bench state
    logic [1:0] lv [17];
    logic [7:0] c0, c1;
    logic [9:0] e;
    logic [31:0] r = 32'h6DFD;
    int         fails = 0;
    int         checks = 0;
    int         cyc = 0;

    // Device drives the wire when enabled
    assign bus = data_oe_n ? host_d : data_out;

    adcp_ctrl #(.OSC_DIV_P(2), .DEPTH_P(FIFO_DEPTH)) i_dut (
        .clk(clk), .rst(rst), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .conversion_start_n(conversion_start_n), .data_in(bus), .data_out(data_out),
        .data_oe_n(data_oe_n), .int_out(int_out), .int_oe_n(int_oe_n),
        .external_clock_in(ext_clk), .core_bits_a(bits_a), .core_bits_b(bits_b),
        .sample_hold(sample_hold), .core_step(core_step), .chan_sel(chan_sel),
        .input_type_select(input_type_select), .dual_mode(dual_mode),
        .power_down(power_down)
    );
    adcp_core_model i_core (
        .clk(clk), .sample_hold(sample_hold), .core_step(core_step), .level_a(la),
        .level_b(lb), .core_bits_a(bits_a), .core_bits_b(bits_b)
    );

    // Clocks
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always #12 ext_clk = ~ext_clk;

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            results();
        end
    end

    // Stimulus register
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected word: pair repeated, masked, sign flipped
    function automatic logic [9:0] expw(input logic [1:0] p, input logic [7:0] c);
        logic [9:0] w;
        w = {5{p}};
        if (c[1:0] == RES_8) begin
            w = w & MASK_8;
        end else if (c[1:0] == RES_4) begin
            w = w & MASK_4;
        end
        if (!c[CR1_BINARY_BIT]) begin
            w = w ^ SIGN_BIT;
        end
        return w;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Write cycle; csv high leaves device unselected
    task automatic wr(input logic [1:0] idx, input logic [7:0] v, input logic csv);
        cs_n = csv;
        wr_n = 1'b0;
        host_d = {idx, v};
        tick(2);
        wr_n = 1'b1;
        tick(1);
        host_d = ~host_d;
        cs_n = 1'b1;
        tick(3);
    endtask
    task automatic cfg(input logic [7:0] a, input logic [7:0] b);
        wr(IDX_CFG_ZERO, a, 1'b0);
        wr(IDX_CFG_ONE, b, 1'b0);
    endtask
    // Read cycle, compare when en set
    task automatic rdc(input logic [9:0] x, input bit en);
        if (cs_n) begin
            cs_n = 1'b0;
            tick(2);
        end
        rd_n = 1'b0;
        tick(3);
        if (en) begin
            chk(data_out, x);
        end
        rd_n = 1'b1;
        tick(3);
    endtask
    task automatic conv(input int n);
        conversion_start_n = 1'b0;
        tick(3);
        chk(sample_hold, 1'b1);
        conversion_start_n = 1'b1;
        tick(n);
    endtask
    task automatic results();
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {rst, cs_n, rd_n, wr_n, conversion_start_n} = 5'h1F;
        {ext_clk, host_d, la, lb} = 15'h0;
        tick(20);
        rst = 1'b0;
        tick(2);
        chk({int_out, data_oe_n, int_oe_n, chan_sel, dual_mode, input_type_select, power_down},
            10'h060);
        // Random writes, then refused ones
        for (int i = 0; i < 4; i++) begin
            r = nxt(r);
            c0 = r[7:0] & 8'h17;
            wr(IDX_CFG_ZERO, c0, 1'b0);
            chk({input_type_select, dual_mode, chan_sel}, {c0[4], c0[2], c0[1:0]});
        end
        wr(2'h2, ~c0, 1'b0);
        wr(IDX_CFG_ZERO, ~c0, 1'b1);
        chk({input_type_select, dual_mode, chan_sel}, {c0[4], c0[2], c0[1:0]});
        // Start strobe unselected, every resolution and format
        for (int m = 0; m < 6; m++) begin
            c1 = 8'h40 | {5'h0, m[0], m[2:1]};
            cfg(8'h00, c1);
            r = nxt(r);
            la = r[1:0];
            conv(30);
            chk(int_oe_n, 1'b0);
            rdc(expw(la, c1), 1'b1);
            chk(int_oe_n, 1'b1);
        end
        // Dual: two words in turn
        r = nxt(r);
        la = r[1:0];
        lb = ~r[1:0];
        cfg({3'h0, r[2], 4'h4}, 8'h40);
        conv(50);
        chk(int_oe_n, 1'b0);
        rdc(expw(la, 8'h40), 1'b1);
        rdc(expw(lb, 8'h40), 1'b1);
        // External clock
        la = ~la;
        cfg(8'h00, 8'hC4);
        conv(80);
        rdc(expw(la, 8'hC4), 1'b1);
        // Read strobe trigger, held interrupt
        cfg(8'h00, 8'h04);
        cs_n = 1'b0;
        tick(2);
        rd_n = 1'b0;
        tick(30);
        chk(int_oe_n, 1'b0);
        rd_n = 1'b1;
        tick(3);
        chk(int_oe_n, 1'b1);
        rdc(expw(la, 8'h04), 1'b1);
        tick(30);
        cs_n = 1'b1;
        tick(3);
        chk(int_oe_n, 1'b1);
        cfg(8'h00, 8'h44);
        rdc(expw(la, 8'h04), 1'b1);
        // Fill past the depth, drain in order
        for (int k = 0; k < 17; k++) begin
            r = nxt(r);
            lv[k] = r[1:0];
            la = r[1:0];
            conv(25);
        end
        for (int k = 0; k < 18; k++) begin
            rdc(expw(lv[k > 16 ? 16 : k], 8'h44), 1'b1);
        end
        // Continuous: each read returns the previous result
        cfg(8'h08, 8'h01);
        for (int k = 0; k < 3; k++) begin
            rdc(e, k > 0);
            e = expw(la, 8'h01);
            r = nxt(r);
            la = r[1:0];
            tick(30);
        end
        chk(int_oe_n, 1'b1);
        // Power-down readback
        cfg(8'h13, 8'h08);
        chk(power_down, 1'b1);
        cs_n = 1'b0;
        tick(2);
        rdc(10'h013, 1'b1);
        rdc(10'h108, 1'b1);
        tick(20);
        chk(int_oe_n, 1'b1);
        results();
    end
endmodule
